// ===== shared/tec_regs.vh
// Register offsets, field positions, reset values and codes of the timer/event counter.
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

// ****************************************
// Register byte offsets (haddr[15:0])
// ****************************************
`define TEC_OFS_CLK_SEL    16'hFF40
`define TEC_OFS_MODE       16'hFF48
`define TEC_OFS_COMPARE    16'hFF50
`define TEC_OFS_CAPTURE    16'hFF54
`define TEC_OFS_COUNT      16'hFF58
`define TEC_OFS_OUT_CTRL   16'hFF5C
`define TEC_OFS_EDGE_MODE  16'hFF60
`define TEC_OFS_SMP_SEL    16'hFF64
`define TEC_OFS_PORT_DIR   16'hFF68

// ****************************************
// Reset values
// ****************************************
`define TEC_RST_CLK_SEL    8'h00
`define TEC_RST_MODE       3'h0
`define TEC_RST_OUT_CTRL   2'h0
`define TEC_RST_EDGE_MODE  8'h00
`define TEC_RST_SMP_SEL    2'h0
`define TEC_RST_PORT_DIR   8'hFF
`define TEC_RST_COUNT      16'h0000

// ****************************************
// Field positions
// ****************************************
`define TEC_CS_CNT_LSB     4
`define TEC_CS_CNT_MSB     6
`define TEC_MD_OVF_BIT     0
`define TEC_MD_SEL_LSB     1
`define TEC_MD_SEL_MSB     3
`define TEC_OC_ENABLE_BIT  0
`define TEC_OC_LEVEL_BIT   1
`define TEC_OC_SET_BIT     2
`define TEC_OC_RESET_BIT   3
`define TEC_EM_EDGE_LSB    2
`define TEC_EM_EDGE_MSB    3

// ****************************************
// Codes
// ****************************************
`define TEC_CNT_PIN        3'h0
`define TEC_CNT_FX1        3'h1
`define TEC_CNT_FX2        3'h2
`define TEC_CNT_FX4        3'h3
`define TEC_CNT_FX8        3'h4
`define TEC_MODE_STOP      3'h0
`define TEC_MODE_PWM       3'h1
`define TEC_EDGE_FALL      2'h0
`define TEC_EDGE_RISE      2'h1
`define TEC_EDGE_BOTH      2'h3
`define TEC_SMP_MASK0      8'h00
`define TEC_SMP_MASK1      8'h03
`define TEC_SMP_MASK2      8'h3F
`define TEC_SMP_MASK3      8'h7F

`endif

// ===== hw/tec_edge_filter.v
// Sampled two-sample edge filter for the shared timer input pin.
`timescale 1ns/10ps
module tec_edge_filter (
  clk,
  rstn,
  pin_in,
  sample_tick,
  edge_sel,
  valid_edge
);
  input  wire       clk;          // System clock.
  input  wire       rstn;         // Synchronous reset, active low.
  input  wire       pin_in;       // Pin level, synchronous to clk.
  input  wire       sample_tick;  // One-cycle strobe that takes a sample.
  input  wire [1:0] edge_sel;     // Active edge code.
  output reg        valid_edge;   // One-cycle pulse on an accepted edge.

  `include "tec_regs.vh"

  reg smp_ff;  // Previous sample.
  reg lvl_ff;  // Accepted stable level.

  // ****************************************
  // Sampling and acceptance
  // ****************************************
  // A new level is accepted only when two consecutive samples agree on it.
  always @(posedge clk) begin
    if (!rstn) begin
      smp_ff     <= 1'b0;
      lvl_ff     <= 1'b0;
      valid_edge <= 1'b0;
    end else begin
      valid_edge <= 1'b0;
      if (sample_tick) begin
        smp_ff <= pin_in;
        if ((pin_in == smp_ff) && (pin_in != lvl_ff)) begin
          lvl_ff <= pin_in;
          case (edge_sel)
            `TEC_EDGE_FALL: valid_edge <= ~pin_in;
            `TEC_EDGE_RISE: valid_edge <= pin_in;
            `TEC_EDGE_BOTH: valid_edge <= 1'b1;
            default:        valid_edge <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule

// ===== hw/tec_top.v
// Sixteen-bit timer/event counter with an AHB-Lite register slave.
//
// Contract
// - Compare each count, pulse match on equality.
// - Lowered compare: count through overflow from 0.
// - Valid pin edge copies count into capture.
// - Capture read blocks capture, edge irq stays.
// - Reset clears counter to zero.
// - Counter read goes through capture register.
// - Clock select: pin, fx, fx/2, fx/4, fx/8.
// - Mode zero stops and clears; nonzero runs.
// - Mode codes pick PWM, free, edge/match clear.
// - Even toggles on match, odd also edge.
// - Overflow sets flag bit 0 of mode.
// - Output control sets, resets, level, inversion.
// - Set and reset bits read back zero.
// - Input sampled at selected sample clock rate.
// - Edge valid after two matching samples.
// - PWM mixes 2^8 basic and 2^14 sub-cycle.
`timescale 1ns/10ps
module tec_top (
  clk,
  rstn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  count_input_pin,
  timer_out_pin,
  timer_out_oe,
  match_irq,
  edge_irq_input
);
  input  wire        clk;              // System clock, 125 MHz.
  input  wire        rstn;             // Synchronous reset, active low.
  input  wire        hsel;             // Slave select.
  input  wire [31:0] haddr;            // Byte address.
  input  wire [1:0]  htrans;           // Transfer type.
  input  wire        hwrite;           // Write when high.
  input  wire [2:0]  hsize;            // Transfer size, whole words only.
  input  wire [31:0] hwdata;           // Write data.
  input  wire        hready;           // Bus ready.
  output reg  [31:0] hrdata;           // Read data.
  output reg         hreadyout;        // Slave ready.
  output reg         hresp;            // Response, always OKAY.
  input  wire        count_input_pin;  // Shared timer input / edge pin.
  output reg         timer_out_pin;    // Timer output level.
  output reg         timer_out_oe;     // Output enable of the timer pin.
  output reg         match_irq;        // Compare match pulse.
  output reg         edge_irq_input;   // Valid input edge pulse.

  `include "tec_regs.vh"

  // ****************************************
  // Functions
  // ****************************************
  // Reverses a 6-bit basic-cycle index to spread extra PWM clocks evenly.
  function [5:0] tec_rev6;
    input [5:0] v;
    begin
      tec_rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
    end
  endfunction

  // Tests a byte address against a register offset.
  function tec_hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      tec_hit = (a == ofs);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0]  clk_sel_ff;     // Count clock select and clock-out bits.
  reg [2:0]  mode_ff;        // Operating mode.
  reg        ovf_ff;         // Overflow flag.
  reg [15:0] cmp_ff;         // Compare value.
  reg [15:0] cap_ff;         // Capture value.
  reg [15:0] cnt_ff;         // Up counter.
  reg [1:0]  oc_ff;          // Output enable and level/inversion bits.
  reg [7:0]  edge_mode_ff;   // Edge mode select.
  reg [1:0]  smp_sel_ff;     // Sample clock select.
  reg [7:0]  port_dir_ff;    // Port direction bits.
  reg        lvff_ff;        // Output flip-flop.
  reg [2:0]  pre_ff;         // Count clock prescaler.
  reg [7:0]  smp_div_ff;     // Sample clock divider.
  reg        wr_pend_ff;     // Write data phase pending.
  reg [15:0] wr_addr_ff;     // Latched write address.
  reg        sample_tick_ff; // Sample strobe to the filter.

  wire        valid_edge;    // Filtered valid edge pulse.
  wire        acc;           // Address phase taken.
  wire        rd_acc;        // Read taken.
  wire [15:0] a_lo;          // Low address bits.
  wire        cap_read;      // Capture register read in progress.
  wire        cnt_read;      // Counter register read in progress.
  wire        wr_mode;       // Write to mode register.
  wire        wr_oc;         // Write to output control register.

  reg         tick;          // Count clock strobe.
  reg  [7:0]  smp_mask;      // Divider mask for the sample clock.
  reg         match;         // Compare match at this count.
  reg  [15:0] nxt_cnt;       // Next counter value.
  reg         nxt_ovf_set;   // Overflow happens this cycle.
  reg         pwm_lvl;       // PWM active phase.
  reg  [8:0]  pwm_width;     // Active clocks in this basic cycle.
  reg  [31:0] nxt_rdata;     // Read mux.

  assign acc      = hsel & htrans[1] & hready;
  assign rd_acc   = acc & ~hwrite;
  assign a_lo     = haddr[15:0];
  assign cap_read = rd_acc & tec_hit(a_lo, `TEC_OFS_CAPTURE);
  assign cnt_read = rd_acc & tec_hit(a_lo, `TEC_OFS_COUNT);
  assign wr_mode  = wr_pend_ff & tec_hit(wr_addr_ff, `TEC_OFS_MODE);
  assign wr_oc    = wr_pend_ff & tec_hit(wr_addr_ff, `TEC_OFS_OUT_CTRL);

  // ****************************************
  // Input edge filter
  // ****************************************
  tec_edge_filter u_filt (
    .clk         (clk),
    .rstn        (rstn),
    .pin_in      (count_input_pin),
    .sample_tick (sample_tick_ff),
    .edge_sel    (edge_mode_ff[`TEC_EM_EDGE_MSB:`TEC_EM_EDGE_LSB]),
    .valid_edge  (valid_edge)
  );

  // ****************************************
  // Clock dividers
  // ****************************************
  // Selects the sample divider mask from the sample clock code.
  always @* begin
    case (smp_sel_ff)
      2'h0:    smp_mask = `TEC_SMP_MASK0;
      2'h1:    smp_mask = `TEC_SMP_MASK1;
      2'h2:    smp_mask = `TEC_SMP_MASK2;
      default: smp_mask = `TEC_SMP_MASK3;
    endcase
  end

  // Free-running prescaler and sample divider.
  always @(posedge clk) begin
    if (!rstn) begin
      pre_ff         <= 3'h0;
      smp_div_ff     <= 8'h00;
      sample_tick_ff <= 1'b0;
    end else begin
      pre_ff         <= pre_ff + 3'h1;
      smp_div_ff     <= smp_div_ff + 8'h01;
      sample_tick_ff <= ((smp_div_ff & smp_mask) == smp_mask);
    end
  end

  // Picks the count clock strobe; prohibited codes never count.
  always @* begin
    case (clk_sel_ff[`TEC_CS_CNT_MSB:`TEC_CS_CNT_LSB])
      `TEC_CNT_PIN: tick = valid_edge;
      `TEC_CNT_FX1: tick = 1'b1;
      `TEC_CNT_FX2: tick = pre_ff[0];
      `TEC_CNT_FX4: tick = (pre_ff[1:0] == 2'h3);
      `TEC_CNT_FX8: tick = (pre_ff == 3'h7);
      default:      tick = 1'b0;
    endcase
  end

  // ****************************************
  // Counter next state
  // ****************************************
  // Computes match, overflow and the next count for the active mode.
  always @* begin
    nxt_cnt     = cnt_ff;
    nxt_ovf_set = 1'b0;
    match       = tick && (cnt_ff == cmp_ff) && (mode_ff != `TEC_MODE_STOP);
    if (mode_ff == `TEC_MODE_STOP) begin
      nxt_cnt = 16'h0000;
    end else if (mode_ff[2:1] == 2'h2 && valid_edge) begin
      nxt_cnt = 16'h0000;
    end else if (tick) begin
      if (mode_ff[2:1] == 2'h3 && match) begin
        nxt_cnt = 16'h0000;
      end else begin
        nxt_cnt     = cnt_ff + 16'h0001;
        nxt_ovf_set = (cnt_ff == 16'hFFFF);
      end
    end
  end

  // Counter, overflow flag and capture register.
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_ff <= `TEC_RST_COUNT;
      ovf_ff <= 1'b0;
      cap_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      // overflow flag, set wins over clear
      if (nxt_ovf_set) begin
        ovf_ff <= 1'b1;
      end else if (wr_mode) begin
        ovf_ff <= hwdata[`TEC_MD_OVF_BIT];
      end
      if (cnt_read) begin
        cap_ff <= cnt_ff;
      end else if (valid_edge && !cap_read) begin
        cap_ff <= cnt_ff;
      end
    end
  end

  // ****************************************
  // PWM generator
  // ****************************************
  // The low 8 count bits walk a basic cycle, the next 6 pick the sub-cycle slot.
  always @* begin
    pwm_width = {1'b0, cmp_ff[15:8]};
    if (tec_rev6(cnt_ff[13:8]) < cmp_ff[7:2]) begin
      pwm_width = {1'b0, cmp_ff[15:8]} + 9'h001;
    end
    pwm_lvl = ({1'b0, cnt_ff[7:0]} < pwm_width);
  end

  // ****************************************
  // Output flip-flop and pin
  // ****************************************
  // Toggles on match or edge per mode; set/reset writes force it.
  always @(posedge clk) begin
    if (!rstn) begin
      lvff_ff       <= 1'b0;
      timer_out_pin <= 1'b0;
      timer_out_oe  <= 1'b0;
    end else begin
      if (wr_oc && hwdata[`TEC_OC_SET_BIT]) begin
        lvff_ff <= 1'b1;
      end else if (wr_oc && hwdata[`TEC_OC_RESET_BIT]) begin
        lvff_ff <= 1'b0;
      end else if (mode_ff != `TEC_MODE_STOP && mode_ff != `TEC_MODE_PWM && oc_ff[`TEC_OC_LEVEL_BIT]) begin
        if (match || (mode_ff[0] && valid_edge)) begin
          lvff_ff <= ~lvff_ff;
        end
      end
      if (!oc_ff[`TEC_OC_ENABLE_BIT]) begin
        timer_out_pin <= 1'b0;
      end else if (mode_ff == `TEC_MODE_PWM) begin
        timer_out_pin <= pwm_lvl ^ oc_ff[`TEC_OC_LEVEL_BIT];
      end else begin
        timer_out_pin <= lvff_ff;
      end
      timer_out_oe <= ~port_dir_ff[0];
    end
  end

  // ****************************************
  // Interrupt pulses
  // ****************************************
  // One-cycle request pulses; the edge pulse fires in every mode.
  always @(posedge clk) begin
    if (!rstn) begin
      match_irq      <= 1'b0;
      edge_irq_input <= 1'b0;
    end else begin
      match_irq      <= match;
      edge_irq_input <= valid_edge;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Read mux; unmapped addresses read zero.
  always @* begin
    nxt_rdata = 32'h00000000;
    case (a_lo)
      `TEC_OFS_CLK_SEL:   nxt_rdata = {24'h000000, clk_sel_ff};
      `TEC_OFS_MODE:      nxt_rdata = {28'h0000000, mode_ff, ovf_ff};
      `TEC_OFS_COMPARE:   nxt_rdata = {16'h0000, cmp_ff};
      `TEC_OFS_CAPTURE:   nxt_rdata = {16'h0000, cap_ff};
      `TEC_OFS_COUNT:     nxt_rdata = {16'h0000, cnt_ff};
      `TEC_OFS_OUT_CTRL:  nxt_rdata = {30'h00000000, oc_ff};
      `TEC_OFS_EDGE_MODE: nxt_rdata = {24'h000000, edge_mode_ff};
      `TEC_OFS_SMP_SEL:   nxt_rdata = {30'h00000000, smp_sel_ff};
      `TEC_OFS_PORT_DIR:  nxt_rdata = {24'h000000, port_dir_ff};
      default:            nxt_rdata = 32'h00000000;
    endcase
  end

  // Bus phases: read data is registered at the address phase, writes land in the data phase.
  always @(posedge clk) begin
    if (!rstn) begin
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 16'h0000;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= acc & hwrite;
      if (acc) begin
        wr_addr_ff <= a_lo;
      end
      if (rd_acc) begin
        hrdata <= nxt_rdata;
      end
    end
  end

  // Software-written registers.
  always @(posedge clk) begin
    if (!rstn) begin
      clk_sel_ff   <= `TEC_RST_CLK_SEL;
      mode_ff      <= `TEC_RST_MODE;
      cmp_ff       <= 16'h0000;
      oc_ff        <= `TEC_RST_OUT_CTRL;
      edge_mode_ff <= `TEC_RST_EDGE_MODE;
      smp_sel_ff   <= `TEC_RST_SMP_SEL;
      port_dir_ff  <= `TEC_RST_PORT_DIR;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `TEC_OFS_CLK_SEL:   clk_sel_ff   <= hwdata[7:0];
        `TEC_OFS_MODE:      mode_ff      <= hwdata[`TEC_MD_SEL_MSB:`TEC_MD_SEL_LSB];
        `TEC_OFS_COMPARE:   cmp_ff       <= hwdata[15:0];
        `TEC_OFS_OUT_CTRL:  oc_ff        <= hwdata[1:0];
        `TEC_OFS_EDGE_MODE: edge_mode_ff <= hwdata[7:0];
        `TEC_OFS_SMP_SEL:   smp_sel_ff   <= hwdata[1:0];
        `TEC_OFS_PORT_DIR:  port_dir_ff  <= hwdata[7:0];
        default:            port_dir_ff  <= port_dir_ff;
      endcase
    end
  end
endmodule

// ===== bench/tec_asserts.sv
// Checker of the timer/event counter port behaviour.
`timescale 1ns/10ps
`include "tec_regs.vh"
module tec_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        count_input_pin,
  input wire logic        timer_out_pin,
  input wire logic        timer_out_oe,
  input wire logic        match_irq,
  input wire logic        edge_irq_input
);
  // ****
  // Bus shadow
  // ****
  logic        ap_ff;    // A data phase is in progress.
  logic        apw_ff;   // That phase is a write.
  logic [15:0] apa_ff;   // Its byte address.
  logic [2:0]  mode_ff;  // Shadow of the mode bits.
  logic        oen_ff;   // Shadow of the output enable.
  logic        dir_ff;   // Shadow of the pin direction bit.
  logic        blk_ff;   // Last capture read saw a refused capture.
  logic [15:0] blkv_ff;  // Value that read returned.
  wire logic   wr_any = ap_ff & apw_ff;
  wire logic   rd_cap = ap_ff & ~apw_ff & (apa_ff == `TEC_OFS_CAPTURE);
  wire logic   rd_cnt = ap_ff & ~apw_ff & (apa_ff == `TEC_OFS_COUNT);
  // Follows transfers into their data phase and keeps register shadows.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ap_ff   <= 1'b0;
      mode_ff <= 3'h0;
      oen_ff  <= 1'b0;
      dir_ff  <= 1'b1;
      blk_ff  <= 1'b0;
    end else begin
      ap_ff  <= hsel & htrans[1] & hready;
      apw_ff <= hwrite;
      apa_ff <= haddr[15:0];
      if (wr_any && apa_ff == `TEC_OFS_MODE) begin
        mode_ff <= hwdata[3:1];
      end
      if (wr_any && apa_ff == `TEC_OFS_OUT_CTRL) begin
        oen_ff <= hwdata[0];
      end
      if (wr_any && apa_ff == `TEC_OFS_PORT_DIR) begin
        dir_ff <= hwdata[0];
      end
      // An edge pulse in a capture read's data phase means its capture was refused.
      if (rd_cap && edge_irq_input) begin
        blk_ff  <= 1'b1;
        blkv_ff <= hrdata[15:0];
      end else if (edge_irq_input || rd_cap || rd_cnt) begin
        blk_ff <= 1'b0;
      end
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_stopped;
    (mode_ff == 3'h0)[*3];
  endsequence
  sequence s_cap_again;
    rd_cap && blk_ff;
  endsequence
  a_match_one_cycle: assert property (match_irq |=> !match_irq)
    else $error("match pulse longer than one cycle");
  a_edge_one_cycle: assert property (edge_irq_input |=> !edge_irq_input)
    else $error("edge pulse longer than one cycle");
  a_match_needs_run: assert property (match_irq |-> $past(mode_ff) != 3'h0)
    else $error("match pulse while stopped");
  a_reset_quiet: assert property ($rose(rstn) |-> !match_irq && !edge_irq_input && !timer_out_oe)
    else $error("outputs active after reset");
  a_oe_from_dir: assert property (timer_out_oe == !$past(dir_ff))
    else $error("output enable does not follow direction bit");
  a_out_disabled_low: assert property ((!oen_ff)[*2] |-> !timer_out_pin)
    else $error("timer output high while disabled");
  a_flip_bits_zero: assert property (ap_ff && !apw_ff && apa_ff == `TEC_OFS_OUT_CTRL |-> hrdata[3:2] == 2'b00)
    else $error("set or reset bit reads back nonzero");
  a_mode_upper_zero: assert property (ap_ff && !apw_ff && apa_ff == `TEC_OFS_MODE |-> hrdata[31:4] == 28'h0)
    else $error("mode register upper bits nonzero");
  a_capture_held: assert property (s_cap_again |-> hrdata[15:0] == blkv_ff)
    else $error("capture taken during capture read");
  a_stop_clears: assert property (s_stopped ##1 rd_cnt |-> hrdata[15:0] == 16'h0000)
    else $error("counter nonzero while stopped");
endmodule
bind tec_top tec_asserts tec_asserts_i (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .count_input_pin, .timer_out_pin, .timer_out_oe, .match_irq, .edge_irq_input);

// ===== bench/tec_pulse_src.sv
// External pulse source on the timer input pin and the load on the output pin.
`timescale 1ns/10ps
module tec_pulse_src (
  input wire logic clk,
  output logic     pin,
  input wire logic timer_out_pin,
  input wire logic timer_out_oe,
  output logic     pad
);
  // ****
  // Source and load
  // ****
  initial pin = 1'b0;
  // The output pad has a pull-up, so it reads high while undriven.
  assign pad = timer_out_oe ? timer_out_pin : 1'b1;
  // Moves the pin to the other level just after an edge.
  task automatic flip();
    @(posedge clk);
    pin <= ~pin;
  endtask
  // Holds the other level for w clocks, then returns.
  task automatic pulse(input int w);
    flip();
    repeat (w - 1) @(posedge clk);
    flip();
  endtask
endmodule

// ===== bench/tec_top_tb.sv
// Self-checking testbench of the timer/event counter.
`timescale 1ns/10ps
`include "tec_regs.vh"
module tec_top_tb;
  logic        clk = 1'b0;    // System clock.
  logic        rstn = 1'b0;   // Reset, active low.
  logic        hsel;          // Bus select.
  logic [31:0] haddr;         // Bus address.
  logic [1:0]  htrans;        // Transfer type.
  logic        hwrite;        // Write flag.
  logic [2:0]  hsize;         // Word transfers only.
  logic [31:0] hwdata;        // Write data.
  wire logic [31:0] hrdata;
  wire logic   hreadyout, hresp, count_input_pin, timer_out_pin, timer_out_oe, match_irq, edge_irq_input, pad;
  int          err_total = 0, total_checks = 0, cyc = 0, n_m = 0, n_e = 0, m0, e0, s, p, h;
  logic [31:0] rd, t, o;
  logic [15:0] ra [8] = '{`TEC_OFS_CLK_SEL, `TEC_OFS_MODE, `TEC_OFS_OUT_CTRL, `TEC_OFS_EDGE_MODE,
                          `TEC_OFS_SMP_SEL, `TEC_OFS_PORT_DIR, `TEC_OFS_COUNT, 16'hFF7C};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
  int          ec [4] = '{0, 1, 3, 2};
  int          ee [4] = '{1, 1, 2, 0};
  always #4 clk = ~clk;
  tec_top tec_top_i (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .count_input_pin, .timer_out_pin, .timer_out_oe, .match_irq, .edge_irq_input);
  tec_pulse_src tec_pulse_src_i (.clk, .pin(count_input_pin), .timer_out_pin, .timer_out_oe, .pad);
  // Counts pulses on settled outputs and cuts a hang short.
  always @(negedge clk) begin
    cyc++;
    if (match_irq === 1'b1) n_m++;
    if (edge_irq_input === 1'b1) n_e++;
    if (cyc == 100000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data is taken at the data phase's closing edge.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    hsel <= 1'b0;
    haddr <= '0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(ra[i], rv[i]);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    wr(`TEC_OFS_COMPARE, 32'h9);
    for (int k = 1; k < 5; k++) begin
      wr(`TEC_OFS_MODE, 32'h0);
      wr(`TEC_OFS_CLK_SEL, k << 4);
      wr(`TEC_OFS_MODE, 32'hC);
      m0 = n_m;
      wait (n_m == m0 + 1);
      s = cyc;
      wait (n_m == m0 + 2);
      chk(cyc - s, 10 << (k - 1));
    end
    wr(`TEC_OFS_MODE, 32'h0);
    rdc(`TEC_OFS_COUNT, 32'h0);
    wr(`TEC_OFS_CLK_SEL, 32'h10);
    wr(`TEC_OFS_COMPARE, 32'hFFFF);
    wr(`TEC_OFS_MODE, 32'hC);
    tk(300);
    m0 = n_m;
    wr(`TEC_OFS_COMPARE, 32'h20);
    s = cyc;
    wait (n_m != m0);
    chk({31'h0, (cyc - s > 65000) && (cyc - s < 65536)}, 32'h1);
    rdc(`TEC_OFS_MODE, 32'hD);
    wr(`TEC_OFS_MODE, 32'h0);
    rdc(`TEC_OFS_MODE, 32'h0);
    wr(`TEC_OFS_PORT_DIR, 32'h0);
    wr(`TEC_OFS_OUT_CTRL, 32'h7);
    tk(2);
    chk({31'h0, pad}, 32'h1);
    rdc(`TEC_OFS_OUT_CTRL, 32'h3);
    wr(`TEC_OFS_OUT_CTRL, 32'hB);
    tk(2);
    chk({31'h0, pad}, 32'h0);
    rdc(`TEC_OFS_OUT_CTRL, 32'h3);
    wr(`TEC_OFS_EDGE_MODE, 32'h4);
    wr(`TEC_OFS_COMPARE, 32'hFFFF);
    for (int m = 2; m < 8; m++) begin
      wr(`TEC_OFS_MODE, 32'h0);
      wr(`TEC_OFS_MODE, m << 1);
      o = {31'h0, pad};
      tec_pulse_src_i.pulse(4);
      tk(8);
      chk({31'h0, pad}, o ^ (m & 1));
    end
    wr(`TEC_OFS_MODE, 32'h0);
    wr(`TEC_OFS_COMPARE, 32'h9);
    wr(`TEC_OFS_MODE, 32'hC);
    m0 = n_m;
    wait (n_m == m0 + 1);
    tk(2);
    o = {31'h0, pad};
    wait (n_m == m0 + 2);
    tk(2);
    chk({31'h0, pad}, o ^ 32'h1);
    wr(`TEC_OFS_MODE, 32'h0);
    wr(`TEC_OFS_MODE, 32'h4);
    tec_pulse_src_i.pulse(4);
    tk(8);
    xfer(1'b0, `TEC_OFS_CAPTURE, 32'h0, o);
    xfer(1'b0, `TEC_OFS_COUNT, 32'h0, t);
    chk({31'h0, (t > o) && (t - o < 40)}, 32'h1);
    xfer(1'b0, `TEC_OFS_COUNT, 32'h0, t);
    rdc(`TEC_OFS_CAPTURE, t);
    wr(`TEC_OFS_MODE, 32'h0);
    wr(`TEC_OFS_MODE, 32'h8);
    tk(60);
    tec_pulse_src_i.pulse(4);
    tk(8);
    xfer(1'b0, `TEC_OFS_CAPTURE, 32'h0, o);
    xfer(1'b0, `TEC_OFS_COUNT, 32'h0, t);
    chk({31'h0, (o > 60) && (t < 30)}, 32'h1);
    wr(`TEC_OFS_EDGE_MODE, 32'hC);
    e0 = n_e;
    for (int off = 0; off < 4; off++) begin
      fork
        repeat (4) xfer(1'b0, `TEC_OFS_CAPTURE, 32'h0, rd);
        begin tk(off + 2); tec_pulse_src_i.flip(); end
      join
    end
    tk(8);
    chk(n_e - e0, 4);
    e0 = n_e;
    tec_pulse_src_i.pulse(1);
    tk(10);
    chk(n_e - e0, 0);
    wr(`TEC_OFS_SMP_SEL, 32'h3);
    tec_pulse_src_i.pulse(100);
    tk(400);
    chk(n_e - e0, 0);
    tec_pulse_src_i.pulse(300);
    tk(400);
    chk(n_e - e0, 2);
    wr(`TEC_OFS_MODE, 32'h0);
    wr(`TEC_OFS_SMP_SEL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`TEC_OFS_EDGE_MODE, ec[i] << 2);
      e0 = n_e;
      tec_pulse_src_i.pulse(6);
      tk(10);
      chk(n_e - e0, ee[i]);
    end
    wr(`TEC_OFS_EDGE_MODE, 32'h4);
    wr(`TEC_OFS_CLK_SEL, 32'h0);
    wr(`TEC_OFS_COMPARE, 32'h3);
    wr(`TEC_OFS_MODE, 32'hC);
    m0 = n_m;
    repeat (3) begin
      tec_pulse_src_i.pulse(6);
      tk(6);
    end
    tk(4);
    chk(n_m - m0, 0);
    rdc(`TEC_OFS_COUNT, 32'h3);
    tec_pulse_src_i.pulse(6);
    tk(10);
    chk(n_m - m0, 1);
    wr(`TEC_OFS_MODE, 32'h0);
    wr(`TEC_OFS_CLK_SEL, 32'h10);
    wr(`TEC_OFS_CLK_SEL, 32'h13);
    wr(`TEC_OFS_CLK_SEL, 32'h93);
    rdc(`TEC_OFS_CLK_SEL, 32'h93);
    wr(`TEC_OFS_OUT_CTRL, 32'h1);
    wr(`TEC_OFS_MODE, 32'h2);
    wr(`TEC_OFS_COMPARE, 32'h8004);
    tk(300);
    h = 0;
    repeat (16384) begin
      tk(1);
      h += pad;
    end
    chk(h, 8193);
    test_done();
  end
endmodule
